// *** core/wake_source_control_regs.sv ***
// Wake source control register bank with wake gating and fail-safe forcing.
// Functional notes
// - Bit 7 enables second timer wake.
// - Bit 6 enables first timer wake.
// - Bit 2 disables watchdog in stop; hardware-updatable.
// - Reserved bits always read back zero.
// - Interrupt scope: wake only, or all status.
// - Measure select disables wake inputs a, b.
// - Measurement runs in normal; ignore a/b levels.
// - Bits 2..0 enable wake inputs c, b, a.
// - External register resets to 0000 0111.
// - Measurement off by default; host enables it.
// - Fail-safe forces external wake enables c, b, a on; bits 7 and 5 keep their value.
// - Pull register holds three two-bit fields.
// - Pull codes: none, pull-down, pull-up.
// - Pull code 11 auto-switches up or down.
// - Watchdog stop-off low bit works with high.
// - CAN codes 001, 101 are wake capable.
`timescale 1ns/1ns
`default_nettype none
module wake_source_control_regs
  import wake_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic wd_stop_hw_write_in,
  input wire logic wd_stop_hw_value_in,
  input wire logic watchdog_stop_off_lo_in,
  output logic [1:0] watchdog_stop_off_out,
  input wire logic fail_safe_entry_in,
  output logic bus_wake_force_out,
  input wire logic [2:0] can_mode_in,
  output logic can_wake_capable_out,
  output logic selective_wake_out,
  input wire logic normal_mode_in,
  output logic measure_active_out,
  input wire logic [2:0] wake_level_in,
  input wire logic [2:0] wake_edge_in,
  output logic [2:0] wake_level_valid_out,
  output logic [2:0] wake_enable_out,
  input wire logic timer1_expire_in,
  input wire logic timer2_expire_in,
  output logic wake_request_out,
  input wire logic status_event_in,
  output logic int_request_out,
  output logic [2:0] pull_up_out,
  output logic [2:0] pull_down_out
);
  logic rst_meta;
  logic rst_n;
  logic [7:0] int_wake;
  logic [7:0] ext_wake;
  logic [7:0] pull_ctrl;
  logic [7:0] next_int_wake;
  logic [7:0] next_ext_wake;
  logic [7:0] next_pull_ctrl;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic bus_force;
  logic next_bus_force;
  logic wake_req;
  logic next_wake_req;
  logic int_req;
  logic next_int_req;
  logic meas_act;
  logic next_meas_act;
  logic [2:0] gated_enable;
  logic wake_any;
  logic can_wake;
  logic can_swk;
  logic [1:0] pull_field [3];

  // Reset release through two flops; the first feeds only the second.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register updates.
  always_comb begin
    next_int_wake = int_wake;
    next_ext_wake = ext_wake;
    next_pull_ctrl = pull_ctrl;
    if (reg_write_in) begin
      case (reg_addr_in)
        INT_WAKE_ADDR:
          next_int_wake = reg_wdata_in & INT_WAKE_MASK;
        EXT_WAKE_ADDR:
          next_ext_wake = reg_wdata_in & EXT_WAKE_MASK;
        PULL_ADDR: next_pull_ctrl = reg_wdata_in & PULL_MASK;
        default: ;
      endcase
    end
    // A device update of the watchdog bit wins over a host write.
    if (wd_stop_hw_write_in) begin
      next_int_wake[WD_STOP_HI_BIT] = wd_stop_hw_value_in;
    end
    // A failure outranks a host write to the external register in the same cycle.
    if (fail_safe_entry_in) begin
      next_ext_wake = (ext_wake & FAIL_SAFE_KEEP) | FAIL_SAFE_FORCE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_wake <= INT_WAKE_RESET;
      ext_wake <= EXT_WAKE_RESET;
      pull_ctrl <= PULL_RESET;
    end else begin
      int_wake <= next_int_wake;
      ext_wake <= next_ext_wake;
      pull_ctrl <= next_pull_ctrl;
    end
  end

  // Read path; stored reserved bits are always zero.
  always_comb begin
    next_rdata = rdata;
    if (reg_read_in) begin
      case (reg_addr_in)
        INT_WAKE_ADDR: next_rdata = int_wake & INT_WAKE_MASK;
        EXT_WAKE_ADDR: next_rdata = ext_wake & EXT_WAKE_MASK;
        PULL_ADDR: next_rdata = pull_ctrl & PULL_MASK;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Wake gating and interrupt scope.
  always_comb begin
    gated_enable[WAKE_C_EN_BIT] = ext_wake[WAKE_C_EN_BIT];
    gated_enable[WAKE_B_EN_BIT] = ext_wake[WAKE_B_EN_BIT]
                                  & ~ext_wake[MEASURE_BIT];
    gated_enable[WAKE_A_EN_BIT] = ext_wake[WAKE_A_EN_BIT]
                                  & ~ext_wake[MEASURE_BIT];
    wake_any = |(wake_edge_in & gated_enable)
               | (timer1_expire_in & int_wake[TIMER1_WAKE_BIT])
               | (timer2_expire_in & int_wake[TIMER2_WAKE_BIT]);
    next_wake_req = wake_any;
    next_int_req = wake_any
                   | (ext_wake[INT_GLOBAL_BIT] & status_event_in);
    next_meas_act = ext_wake[MEASURE_BIT] & normal_mode_in;
    next_bus_force = fail_safe_entry_in;
    can_wake = (can_mode_in == CAN_WAKE_PLAIN)
               | (can_mode_in == CAN_WAKE_SELECTIVE);
    can_swk = can_mode_in == CAN_WAKE_SELECTIVE;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      wake_req <= 1'b0;
      int_req <= 1'b0;
      meas_act <= 1'b0;
      bus_force <= 1'b0;
    end else begin
      rdata <= next_rdata;
      wake_req <= next_wake_req;
      int_req <= next_int_req;
      meas_act <= next_meas_act;
      bus_force <= next_bus_force;
    end
  end

  assign pull_field[0] = pull_ctrl[PULL_A_LSB +: 2];
  assign pull_field[1] = pull_ctrl[PULL_B_LSB +: 2];
  assign pull_field[2] = pull_ctrl[PULL_C_LSB +: 2];

  for (genvar i = 0; i < 3; i++) begin : g_pull
    wake_pull_decode u_pull (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .code_in(pull_field[i]),
      .level_in(wake_level_in[i]),
      .pull_up_out(pull_up_out[i]),
      .pull_down_out(pull_down_out[i])
    );
  end

  assign reg_rdata_out = rdata;
  // Both stop-off bits go out together; the watchdog combines them.
  assign watchdog_stop_off_out = {int_wake[WD_STOP_HI_BIT],
                                  watchdog_stop_off_lo_in};
  assign bus_wake_force_out = bus_force;
  assign can_wake_capable_out = can_wake;
  assign selective_wake_out = can_swk;
  assign measure_active_out = meas_act;
  // Level status of inputs a and b is void while measuring.
  assign wake_level_valid_out = {1'b1, {2{~ext_wake[MEASURE_BIT]}}};
  assign wake_enable_out = gated_enable;
  assign wake_request_out = wake_req;
  assign int_request_out = int_req;

  sequence s_fail_safe;
    fail_safe_entry_in;
  endsequence

  sequence s_ext_forced;
    ext_wake[2:0] == 3'b111 && ext_wake[6] == 1'b0 && ext_wake[4:3] == 2'b00;
  endsequence

  property p_fail_safe_force;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_fail_safe |=> s_ext_forced
                      ##0 (ext_wake & FAIL_SAFE_KEEP)
                          == ($past(ext_wake) & FAIL_SAFE_KEEP);
  endproperty
  a_fail_safe_force: assert property (p_fail_safe_force)
    else $error("Fail-safe entry did not force the external wake register.");

  property p_bus_force;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_fail_safe |=> bus_wake_force_out;
  endproperty
  a_bus_force: assert property (p_bus_force)
    else $error("Fail-safe entry did not request bus wake capability.");

  // The force follows the entry one cycle later, so it ends one cycle after the entry pulse ends.
  property p_bus_force_end;
    @(posedge sys_clk_in) disable iff (!rst_n)
      !fail_safe_entry_in |=> !bus_wake_force_out;
  endproperty
  a_bus_force_end: assert property (p_bus_force_end)
    else $error("Bus wake force outlasted the fail-safe entry pulse.");

  property p_reserved_read;
    @(posedge sys_clk_in) disable iff (!rst_n)
      reg_read_in && reg_addr_in == EXT_WAKE_ADDR
      |=> (reg_rdata_out & ~EXT_WAKE_MASK) == 8'h00
          && reg_rdata_out == $past(ext_wake);
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("External wake read returned a reserved bit set.");

  property p_measure_ignore;
    @(posedge sys_clk_in) disable iff (!rst_n)
      ext_wake[MEASURE_BIT] |-> wake_enable_out[1:0] == 2'b00
                                && wake_level_valid_out[1:0] == 2'b00;
  endproperty
  a_measure_ignore: assert property (p_measure_ignore)
    else $error("Wake inputs a or b remained enabled while measuring.");

  property p_measure_normal;
    @(posedge sys_clk_in) disable iff (!rst_n)
      ext_wake[MEASURE_BIT] && normal_mode_in |=> measure_active_out;
  endproperty
  a_measure_normal: assert property (p_measure_normal)
    else $error("Measurement did not run in normal mode.");

  property p_timer_wake;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (timer2_expire_in && int_wake[TIMER2_WAKE_BIT])
      || (timer1_expire_in && int_wake[TIMER1_WAKE_BIT])
      |=> wake_request_out && int_request_out;
  endproperty
  a_timer_wake: assert property (p_timer_wake)
    else $error("Enabled timer expiry gave no wake request.");

  property p_int_scope;
    @(posedge sys_clk_in) disable iff (!rst_n)
      !ext_wake[INT_GLOBAL_BIT] && status_event_in && !wake_any
      |=> !int_request_out;
  endproperty
  a_int_scope: assert property (p_int_scope)
    else $error("Status event raised the interrupt outside global scope.");

  property p_wd_hw_update;
    @(posedge sys_clk_in) disable iff (!rst_n)
      wd_stop_hw_write_in
      |=> watchdog_stop_off_out[1] == $past(wd_stop_hw_value_in);
  endproperty
  a_wd_hw_update: assert property (p_wd_hw_update)
    else $error("Device update of the watchdog stop bit was lost.");

  property p_can_wake;
    @(posedge sys_clk_in) disable iff (!rst_n)
      can_mode_in == CAN_WAKE_SELECTIVE
      |-> can_wake_capable_out && selective_wake_out;
  endproperty
  a_can_wake: assert property (p_can_wake)
    else $error("Selective CAN wake code not decoded as wake capable.");

  property p_write_ext;
    @(posedge sys_clk_in) disable iff (!rst_n)
      reg_write_in && reg_addr_in == EXT_WAKE_ADDR && !fail_safe_entry_in
      |=> ext_wake == ($past(reg_wdata_in) & EXT_WAKE_MASK);
  endproperty
  a_write_ext: assert property (p_write_ext)
    else $error("External wake write stored a wrong value.");

  property p_wake_input;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (wake_edge_in[2] && ext_wake[WAKE_C_EN_BIT])
      || (|(wake_edge_in[1:0] & ext_wake[1:0]) && !ext_wake[MEASURE_BIT])
      |=> wake_request_out;
  endproperty
  a_wake_input: assert property (p_wake_input)
    else $error("Enabled wake input event gave no wake request.");

  property p_reserved_store;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (int_wake & ~INT_WAKE_MASK) == 8'h00
      && (pull_ctrl & ~PULL_MASK) == 8'h00;
  endproperty
  a_reserved_store: assert property (p_reserved_store)
    else $error("A reserved wake register position was stored as set.");
endmodule // wake_source_control_regs
`default_nettype wire

// *** inc/wake_ctrl_pkg.sv ***
// Package with register map, field layout and encodings of the wake registers.
package wake_ctrl_pkg;
  localparam logic [6:0] INT_WAKE_ADDR = 7'h06;
  localparam logic [6:0] EXT_WAKE_ADDR = 7'h07;
  localparam logic [6:0] PULL_ADDR = 7'h08;

  localparam logic [7:0] INT_WAKE_RESET = 8'h00;
  localparam logic [7:0] EXT_WAKE_RESET = 8'h07;
  localparam logic [7:0] PULL_RESET = 8'h00;

  // Writable positions; every other position reads as zero.
  localparam logic [7:0] INT_WAKE_MASK = 8'hC4;
  localparam logic [7:0] EXT_WAKE_MASK = 8'hA7;
  localparam logic [7:0] PULL_MASK = 8'h3F;

  localparam int TIMER2_WAKE_BIT = 7;
  localparam int TIMER1_WAKE_BIT = 6;
  localparam int WD_STOP_HI_BIT = 2;
  localparam int INT_GLOBAL_BIT = 7;
  localparam int MEASURE_BIT = 5;
  localparam int WAKE_C_EN_BIT = 2;
  localparam int WAKE_B_EN_BIT = 1;
  localparam int WAKE_A_EN_BIT = 0;
  localparam int PULL_C_LSB = 4;
  localparam int PULL_B_LSB = 2;
  localparam int PULL_A_LSB = 0;

  // Fail-safe entry keeps the x positions and forces the rest.
  localparam logic [7:0] FAIL_SAFE_KEEP = 8'hA0;
  localparam logic [7:0] FAIL_SAFE_FORCE = 8'h07;
  localparam logic [2:0] CAN_WAKE_FORCE = 3'h1;

  localparam logic [2:0] CAN_WAKE_PLAIN = 3'h1;
  localparam logic [2:0] CAN_WAKE_SELECTIVE = 3'h5;

  typedef enum logic [1:0] {
    PULL_NONE = 2'b00,
    PULL_DOWN = 2'b01,
    PULL_UP = 2'b10,
    PULL_AUTO = 2'b11
  } pull_code_t;
endpackage

// *** core/wake_pull_decode.sv ***
// Decoder from one pull configuration field to resistor enables.
`timescale 1ns/1ns
`default_nettype none
module wake_pull_decode
  import wake_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] code_in,
  input wire logic level_in,
  output logic pull_up_out,
  output logic pull_down_out
);
  logic pull_up;
  logic pull_down;
  logic next_pull_up;
  logic next_pull_down;

  always_comb begin
    case (pull_code_t'(code_in))
      PULL_NONE: begin
        next_pull_up = 1'b0;
        next_pull_down = 1'b0;
      end
      PULL_DOWN: begin
        next_pull_up = 1'b0;
        next_pull_down = 1'b1;
      end
      PULL_UP: begin
        next_pull_up = 1'b1;
        next_pull_down = 1'b0;
      end
      PULL_AUTO: begin
        // The resistor follows the pin level so it holds the present state.
        next_pull_up = level_in;
        next_pull_down = ~level_in;
      end
      default: begin
        next_pull_up = 1'b0;
        next_pull_down = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pull_up <= 1'b0;
      pull_down <= 1'b0;
    end else begin
      pull_up <= next_pull_up;
      pull_down <= next_pull_down;
    end
  end

  assign pull_up_out = pull_up;
  assign pull_down_out = pull_down;

  property p_pull_down_code;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      code_in == PULL_DOWN |=> pull_down && !pull_up;
  endproperty
  a_pull_down_code: assert property (p_pull_down_code)
    else $error("Pull-down code did not select the pull-down resistor.");

  property p_pull_auto;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      code_in == PULL_AUTO
      |=> pull_up == $past(level_in) && pull_down != pull_up;
  endproperty
  a_pull_auto: assert property (p_pull_auto)
    else $error("Automatic pull did not follow the input level.");
endmodule // wake_pull_decode
`default_nettype wire

// *** sim/host_model.sv ***
// Host model that drives the byte-wide register port of the wake bank.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [6:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [2:0] can_mode_out
);
  initial begin
    reg_addr_out = 7'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    can_mode_out = 3'h0;
  end

  // Released write data shows the inverse so a late sample cannot pass.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_write_out = 1'b1;
    @(negedge sys_clk_in);
    reg_write_out = 1'b0;
    reg_wdata_out = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_read_out = 1'b1;
    @(negedge sys_clk_in);
    reg_read_out = 1'b0;
    d = reg_rdata_in;
  endtask

  // The host owns the bus control mode that makes the CAN bus wake.
  task automatic set_can(input logic [2:0] m);
    @(negedge sys_clk_in);
    can_mode_out = m;
  endtask
endmodule // host_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the wake source control register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); \
  end \
end
module tb
  import wake_ctrl_pkg::*;
;
  logic sys_clk_in, arst_n_in, reg_write_in, reg_read_in;
  logic [6:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic wd_stop_hw_write_in, wd_stop_hw_value_in, watchdog_stop_off_lo_in;
  logic fail_safe_entry_in, bus_wake_force_out, normal_mode_in;
  logic can_wake_capable_out, selective_wake_out, measure_active_out;
  logic [2:0] can_mode_in, wake_level_in, wake_edge_in, wake_enable_out;
  logic [2:0] wake_level_valid_out, pull_up_out, pull_down_out;
  logic timer1_expire_in, timer2_expire_in, status_event_in;
  logic wake_request_out, int_request_out;
  logic [1:0] watchdog_stop_off_out;
  logic [1:0] c;
  logic [2:0] exp_up, exp_down;
  int fails, compares;

  host_model host (
    .sys_clk_in(sys_clk_in),
    .reg_rdata_in(reg_rdata_out),
    .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in),
    .reg_write_out(reg_write_in),
    .reg_read_out(reg_read_in),
    .can_mode_out(can_mode_in)
  );

  wake_source_control_regs DUT (
    .sys_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out,
    .wd_stop_hw_write_in, .wd_stop_hw_value_in,
    .watchdog_stop_off_lo_in, .watchdog_stop_off_out,
    .fail_safe_entry_in, .bus_wake_force_out, .can_mode_in,
    .can_wake_capable_out, .selective_wake_out, .normal_mode_in,
    .measure_active_out, .wake_level_in, .wake_edge_in,
    .wake_level_valid_out, .wake_enable_out, .timer1_expire_in,
    .timer2_expire_in, .wake_request_out, .status_event_in,
    .int_request_out, .pull_up_out, .pull_down_out
  );

  always #25 sys_clk_in = ~sys_clk_in;

  task automatic chkreg(input logic [6:0] a, input logic [7:0] ex);
    logic [7:0] d;
    host.rd(a, d);
    `CHK("reg", ex, d)
  endtask

  // Pulses one event: 0..2 wake inputs, 3..4 timers, 5 status, 6 fail-safe.
  task automatic ev(input int k);
    @(negedge sys_clk_in);
    {fail_safe_entry_in, status_event_in, timer2_expire_in,
     timer1_expire_in, wake_edge_in} = 7'h01 << k;
    @(negedge sys_clk_in);
    {fail_safe_entry_in, status_event_in, timer2_expire_in,
     timer1_expire_in, wake_edge_in} = 7'h00;
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fails++;
    finish_test();
  end

  initial begin
    sys_clk_in = 1'b0;
    arst_n_in = 1'b0;
    {wd_stop_hw_write_in, wd_stop_hw_value_in} = 2'b00;
    watchdog_stop_off_lo_in = 1'b0;
    normal_mode_in = 1'b0;
    wake_level_in = 3'b101;
    {fail_safe_entry_in, status_event_in, timer2_expire_in,
     timer1_expire_in, wake_edge_in} = 7'h00;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in) arst_n_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chkreg(7'h06, 8'h00);
    chkreg(7'h07, 8'h07);
    chkreg(7'h08, 8'h00);
    chkreg(7'h05, 8'h00);
    `CHK("wake_en", 3'b111, wake_enable_out)
    host.wr(7'h06, 8'hFF);
    chkreg(7'h06, 8'hC4);
    host.wr(7'h08, 8'hFF);
    chkreg(7'h08, 8'h3F);
    host.wr(7'h07, 8'hFF);
    chkreg(7'h07, 8'hA7);
    `CHK("wake_en", 3'b100, wake_enable_out)
    `CHK("lvl_valid", 3'b100, wake_level_valid_out)
    `CHK("meas", 1'b0, measure_active_out)
    @(negedge sys_clk_in) normal_mode_in = 1'b1;
    @(negedge sys_clk_in);
    `CHK("meas", 1'b1, measure_active_out)
    ev(0);
    `CHK("wake", 1'b0, wake_request_out)
    ev(2);
    `CHK("wake", 1'b1, wake_request_out)
    ev(5);
    `CHK("int", 1'b1, int_request_out)
    host.wr(7'h07, 8'hA0);
    ev(6);
    `CHK("bus_force", 1'b1, bus_wake_force_out)
    @(negedge sys_clk_in);
    `CHK("bus_force", 1'b0, bus_wake_force_out)
    chkreg(7'h07, 8'hA7);
    host.wr(7'h07, 8'h00);
    ev(5);
    `CHK("int", 1'b0, int_request_out)
    for (int k = 0; k < 3; k++) begin
      host.wr(7'h07, 8'h01 << k);
      for (int j = 0; j < 3; j++) begin
        ev(j);
        `CHK("wake", j == k, wake_request_out)
        `CHK("int", j == k, int_request_out)
      end
    end
    for (int k = 0; k < 2; k++) begin
      host.wr(7'h06, 8'h40 << k);
      for (int j = 3; j < 5; j++) begin
        ev(j);
        `CHK("timer", j - 3 == k, wake_request_out)
      end
    end
    watchdog_stop_off_lo_in = 1'b1;
    @(negedge sys_clk_in);
    {wd_stop_hw_write_in, wd_stop_hw_value_in} = 2'b11;
    @(negedge sys_clk_in);
    {wd_stop_hw_write_in, wd_stop_hw_value_in} = 2'b00;
    chkreg(7'h06, 8'h84);
    `CHK("wd", 2'b11, watchdog_stop_off_out)
    host.wr(7'h06, 8'h00);
    `CHK("wd", 2'b01, watchdog_stop_off_out)
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      host.wr(7'h08, {2'b11, c, c, c});
      @(negedge sys_clk_in);
      exp_up = {3{c == 2'h2}} | ({3{c == 2'h3}} & wake_level_in);
      exp_down = {3{c == 2'h1}} | ({3{c == 2'h3}} & ~wake_level_in);
      `CHK("pu", exp_up, pull_up_out)
      `CHK("pd", exp_down, pull_down_out)
      chkreg(7'h08, {2'b00, c, c, c});
    end
    // Automatic pull must follow a change of the input levels.
    wake_level_in = 3'h2;
    @(negedge sys_clk_in);
    `CHK("pu_auto", 3'h2, pull_up_out)
    `CHK("pd_auto", 3'h5, pull_down_out)
    for (int m = 0; m < 8; m++) begin
      host.set_can(m[2:0]);
      #1;
      `CHK("can_wk", m[1:0] == 2'b01, can_wake_capable_out)
      `CHK("swk", m == 5, selective_wake_out)
    end
    // A second reset in mid-run must restore the external and pull register defaults.
    @(negedge sys_clk_in) arst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chkreg(7'h07, 8'h07);
    chkreg(7'h08, 8'h00);
    `CHK("wake_en", 3'b111, wake_enable_out)
    finish_test();
  end
endmodule // tb
`default_nettype wire
